// ---- host_model.sv ----
// Host-side model of the dual-role attention/ignition pin.
// Assumes one clock; the bench gives the wanted attention and ignition levels.
`timescale 1ns/10ps
module host_model (
	input wire logic sys_clk_i,
	input wire logic want_attn_i,
	input wire logic busy_mode_i,
	input wire logic busy_pin_i,
	input wire logic ign_level_i,
	output logic pin_o
);
	// ============================================================
	// Attention hold
	logic hold_ff = 1'b0; // Pin held low by the host
	// Keep the pin low until the busy output shows idle
	always_ff @(posedge sys_clk_i) begin
		hold_ff <= want_attn_i | (hold_ff & busy_mode_i & busy_pin_i);
	end
	// Ignition level passes through when the host is not asking
	assign pin_o = hold_ff ? 1'b0 : ign_level_i;
endmodule : host_model

// ---- obd_adapter_pin_control.sv ----
// Pin-level control of the OBD-to-UART adapter: transceiver modes, channel select,
// dual-role ignition/attention input, power/busy output, straps and indicators.
// Assumes all pin inputs are asynchronous to sys_clk_i; core inputs are synchronous.
//
// Summary of operation
// - Single-wire mode pins encode four modes
// - Options 7 and 2 set: debounced low sleeps
// - Ignition high again: wait 1/5 s, wake
// - Rising measurement input always wakes device
// - Otherwise input is active-low attention request
// - Default options make input attention request
// - Option 7 set: power output, sleeping level, inverted by option 6
// - Option 7 clear: busy output high processing
// - Baud strap at reset: high 115200 or stored rate, low 9600
// - Memory strap sets default, commands change
// - Channel select pins encode CAN channel
// - Tool load output follows tool command
// - Fast/medium transceiver mode: low fast, high sleep
// - Power indicator high running, low sleeping
// - Key falling, unconnected: discoverable 300 s
// - Activity indicators rest high, low transferring
// - Module indicator low working, high sleeping
// - Host link 8N1, default 115200, selectable
// - PWM receive input active low, idle high
// - Bus+ drive active high, separate Bus- drive
`timescale 1ns/10ps
`include "obd_pin_map.svh"

module obd_adapter_pin_control #(
	parameter int unsigned DEBOUNCE_CYCLES = 500000,
	parameter int unsigned WAKE_SHORT_CYCLES = `WAKE_SHORT_S * `CLK_HZ,
	parameter int unsigned WAKE_LONG_CYCLES = `WAKE_LONG_S * `CLK_HZ,
	parameter longint unsigned DISCOVER_CYCLES = `DISCOVER_S * 64'(`CLK_HZ)
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] power_control_options_i,
	input wire logic stored_baud_valid_i,
	input wire logic [31:0] stored_baud_setting_i,
	input wire logic ignition_monitor_input_i,
	input wire logic measure_pin_i,
	input wire logic baud_strap_i,
	input wire logic memory_strap_i,
	input wire logic memory_on_command_i,
	input wire logic memory_off_command_i,
	input wire logic busy_i,
	input wire logic sleep_request_i,
	input wire obd_pin_pkg::sw_req_e sw_mode_req_i,
	input wire obd_pin_pkg::chan_e chan_req_i,
	input wire logic tool_load_command_i,
	input wire logic hs_xcvr_sleep_i,
	input wire logic ms_xcvr_sleep_i,
	input wire logic key_pin_i,
	input wire logic module_connected_i,
	input wire logic module_sleep_i,
	input wire obd_pin_pkg::activity_s activity_i,
	input wire logic pwm_rx_pin_i,
	input wire logic bus_plus_drive_i,
	input wire logic bus_minus_drive_i,
	output obd_pin_pkg::sw_mode_s single_wire_mode_o,
	output obd_pin_pkg::chan_sel_s channel_select_o,
	output logic high_speed_xcvr_mode_out_o,
	output logic medium_speed_xcvr_mode_out_o,
	output logic tool_load_enable_out_o,
	output logic power_switch_output_o,
	output logic attention_o,
	output logic low_power_o,
	output logic warm_start_o,
	output logic [31:0] baud_rate_o,
	output logic memory_enable_o,
	output logic discoverable_o,
	output logic power_indicator_o,
	output logic module_indicator_o,
	output obd_pin_pkg::activity_s activity_indicator_o,
	output logic pwm_rx_active_o,
	output logic bus_plus_tx_o,
	output logic bus_minus_tx_o
);
	// Elaboration check: every count needs a cycle; the window counter is 36 bits wide
	if (DEBOUNCE_CYCLES < 1 || WAKE_SHORT_CYCLES < 1 || WAKE_LONG_CYCLES < 1 ||
			DISCOVER_CYCLES < 1 || DISCOVER_CYCLES > 64'h0000000FFFFFFFFF) begin : g_bad_counts
		$error("Counts must be at least one cycle and fit their counters");
	end

	// ============================================================
	// Pin synchronisers
	// Two stages per pin; only the second stage is read by logic
	localparam int NSYNC = 5;
	logic [NSYNC-1:0] pin_raw; // Raw pin levels
	logic [NSYNC-1:0] sync1_ff; // First stage
	logic [NSYNC-1:0] sync2_ff; // Second stage, safe to read
	assign pin_raw = {ignition_monitor_input_i, measure_pin_i, key_pin_i, baud_strap_i,
		memory_strap_i};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					sync1_ff[gi] <= 1'b1;
					sync2_ff[gi] <= 1'b1;
				end else begin
					sync1_ff[gi] <= pin_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate
	logic ign_s, meas_s, key_s, baud_s, mem_s;
	assign ign_s = sync2_ff[4];
	assign meas_s = sync2_ff[3];
	assign key_s = sync2_ff[2];
	assign baud_s = sync2_ff[1];
	assign mem_s = sync2_ff[0];

	// Delayed copies for edge detection
	logic meas_d_ff; // Previous measurement level
	logic key_d_ff; // Previous key level
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meas_d_ff <= 1'b1;
			key_d_ff <= 1'b1;
		end else begin
			meas_d_ff <= meas_s;
			key_d_ff <= key_s;
		end
	end
	logic meas_rise;
	logic key_fall;
	assign meas_rise = meas_s & ~meas_d_ff;
	assign key_fall = key_d_ff & ~key_s;

	// ============================================================
	// Dual-role input decode
	logic ign_mode; // Input acts as ignition monitor
	assign ign_mode = power_control_options_i[`PWR_OPT_ENABLE_BIT] &
		power_control_options_i[`PWR_OPT_IGN_BIT];
	// Attention request only when not ignition monitor; default options land here
	assign attention_o = ~ign_mode & ~ign_s;

	// ============================================================
	// Ignition debounce
	logic [31:0] deb_cnt_ff; // Cycles the input has stayed low
	logic ign_low_deb; // Low level persisted long enough
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			deb_cnt_ff <= 32'h0;
		end else if (!ign_mode || ign_s) begin
			deb_cnt_ff <= 32'h0;
		end else if (deb_cnt_ff < DEBOUNCE_CYCLES) begin
			deb_cnt_ff <= deb_cnt_ff + 32'h1;
		end
	end
	assign ign_low_deb = (deb_cnt_ff >= DEBOUNCE_CYCLES);

	// ============================================================
	// Power state machine
	// Wake delay counts only while ignition is high; a drop restarts the wait
	obd_pin_pkg::pwr_state_e pwr_ff;
	logic [31:0] wake_cnt_ff; // Cycles spent waiting after ignition return
	logic [31:0] wake_target; // Wait length chosen by option bit 1
	assign wake_target = power_control_options_i[`PWR_OPT_DELAY_BIT] ? WAKE_LONG_CYCLES :
		WAKE_SHORT_CYCLES;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwr_ff <= obd_pin_pkg::PWR_RUN;
			wake_cnt_ff <= 32'h0;
			warm_start_o <= 1'b0;
		end else begin
			warm_start_o <= 1'b0;
			unique case (pwr_ff)
				obd_pin_pkg::PWR_RUN: begin
					wake_cnt_ff <= 32'h0;
					if ((ign_mode && ign_low_deb) || sleep_request_i) begin
						pwr_ff <= obd_pin_pkg::PWR_LOW;
					end
				end
				obd_pin_pkg::PWR_LOW: begin
					wake_cnt_ff <= 32'h0;
					if (meas_rise) begin
						pwr_ff <= obd_pin_pkg::PWR_RUN;
						warm_start_o <= 1'b1;
					end else if (ign_mode && ign_s) begin
						pwr_ff <= obd_pin_pkg::PWR_WAKE_WAIT;
					end
				end
				obd_pin_pkg::PWR_WAKE_WAIT: begin
					if (meas_rise) begin
						pwr_ff <= obd_pin_pkg::PWR_RUN;
						warm_start_o <= 1'b1;
					end else if (!ign_s || !ign_mode) begin
						pwr_ff <= obd_pin_pkg::PWR_LOW;
					end else if (wake_cnt_ff + 32'h1 >= wake_target) begin
						pwr_ff <= obd_pin_pkg::PWR_RUN;
						warm_start_o <= 1'b1;
					end else begin
						wake_cnt_ff <= wake_cnt_ff + 32'h1;
					end
				end
				default: pwr_ff <= obd_pin_pkg::PWR_RUN;
			endcase
		end
	end
	assign low_power_o = (pwr_ff != obd_pin_pkg::PWR_RUN);

	// ============================================================
	// Power / busy output and sleep-dependent indicators
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			power_switch_output_o <= 1'b0;
			power_indicator_o <= 1'b0;
			module_indicator_o <= 1'b1;
		end else begin
			if (power_control_options_i[`PWR_OPT_ENABLE_BIT]) begin
				power_switch_output_o <= power_control_options_i[`PWR_OPT_LEVEL_BIT] ^
					low_power_o;
			end else begin
				power_switch_output_o <= busy_i;
			end
			power_indicator_o <= ~low_power_o;
			module_indicator_o <= module_sleep_i;
		end
	end

	// ============================================================
	// Straps: taken on the third edge after release, once both sync stages hold the pin;
	// sampling earlier would see the synchronisers' reset level instead of the strap
	logic [1:0] strap_cnt_ff; // Edges since release, parks at 3 once straps are taken
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_cnt_ff <= 2'h0;
			baud_rate_o <= `BAUD_HIGH;
			memory_enable_o <= 1'b0;
		end else if (strap_cnt_ff != 2'h3) begin
			strap_cnt_ff <= strap_cnt_ff + 2'h1;
			// Sync pipeline full: sample both straps exactly once
			if (strap_cnt_ff == 2'h2) begin
				if (baud_s) begin
					baud_rate_o <= stored_baud_valid_i ? stored_baud_setting_i : `BAUD_HIGH;
				end else begin
					baud_rate_o <= `BAUD_LOW;
				end
				memory_enable_o <= mem_s;
			end
		end else if (memory_on_command_i) begin
			memory_enable_o <= 1'b1;
		end else if (memory_off_command_i) begin
			memory_enable_o <= 1'b0;
		end
	end

	// ============================================================
	// Discoverable window after key press
	// 36 bits so that a full 300 s window at the core clock fits without wrapping
	logic [35:0] disc_cnt_ff; // Remaining discoverable cycles
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			disc_cnt_ff <= 36'h0;
		end else if (key_fall && !module_connected_i) begin
			disc_cnt_ff <= 36'(DISCOVER_CYCLES);
		end else if (disc_cnt_ff != 36'h0) begin
			disc_cnt_ff <= disc_cnt_ff - 36'h1;
		end
	end
	assign discoverable_o = (disc_cnt_ff != 36'h0);

	// ============================================================
	// Transceiver, channel and indicator outputs registered from core requests
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			single_wire_mode_o <= '0;
			channel_select_o <= '0;
			high_speed_xcvr_mode_out_o <= 1'b1;
			medium_speed_xcvr_mode_out_o <= 1'b1;
			tool_load_enable_out_o <= 1'b0;
			activity_indicator_o <= 4'hF;
			pwm_rx_active_o <= 1'b0;
			bus_plus_tx_o <= 1'b0;
			bus_minus_tx_o <= 1'b0;
		end else begin
			single_wire_mode_o <= sw_mode_req_i;
			channel_select_o <= chan_req_i;
			high_speed_xcvr_mode_out_o <= hs_xcvr_sleep_i;
			medium_speed_xcvr_mode_out_o <= ms_xcvr_sleep_i;
			tool_load_enable_out_o <= tool_load_command_i;
			activity_indicator_o <= ~activity_i;
			pwm_rx_active_o <= ~pwm_rx_pin_i;
			bus_plus_tx_o <= bus_plus_drive_i;
			bus_minus_tx_o <= bus_minus_drive_i;
		end
	end

	// ============================================================
	// Assertions
	a_sleep_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(pwr_ff == obd_pin_pkg::PWR_RUN && ign_mode && ign_low_deb) |=> low_power_o)
		else $error("Debounced ignition low did not enter low power");
	a_meas_wake: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(low_power_o && meas_rise) |=> !low_power_o && warm_start_o)
		else $error("Measurement rise did not wake");
	a_attn_role: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ign_mode |-> !attention_o)
		else $error("Attention asserted in ignition mode");
	a_power_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		power_control_options_i[7] |=> power_switch_output_o ==
		($past(power_control_options_i[6]) ^ $past(low_power_o)))
		else $error("Power output level wrong");
	a_busy_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!power_control_options_i[7] |=> power_switch_output_o == $past(busy_i))
		else $error("Busy output does not follow processing");
	a_power_led: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		low_power_o [*2] |-> !power_indicator_o)
		else $error("Power indicator high while sleeping");
	a_disc_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(key_fall && !module_connected_i) |=> discoverable_o [*3])
		else $error("Discoverable window not opened");
	a_debounce_min: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(ign_low_deb) |-> deb_cnt_ff == DEBOUNCE_CYCLES)
		else $error("Debounce ended early");
	a_chan_sel: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		1'b1 |=> channel_select_o == $past(chan_req_i))
		else $error("Channel select mismatch");
endmodule : obd_adapter_pin_control

// ---- obd_pin_map.svh ----
// Constants for the adapter pin control block: option bit positions, defaults, timing.
// Assumes inclusion by bare name from the design module.
`ifndef OBD_PIN_MAP_SVH
`define OBD_PIN_MAP_SVH
// ============================================================
// Power control option bit positions
`define PWR_OPT_ENABLE_BIT 7
`define PWR_OPT_LEVEL_BIT 6
`define PWR_OPT_IGN_BIT 2
`define PWR_OPT_DELAY_BIT 1
// Default power control options after reset (bit 7 set, bit 2 clear)
`define PWR_OPT_RESET 8'h80
// ============================================================
// Baud selections
`define BAUD_HIGH 32'd115200
`define BAUD_LOW 32'd9600
// ============================================================
// Timing
`define CLK_HZ 32'd50000000
`define WAKE_SHORT_S 1
`define WAKE_LONG_S 5
`define DISCOVER_S 300
`endif

// ---- obd_pin_pkg.sv ----
// Types for the adapter pin control block.
// Assumes obd_pin_map.svh holds the numeric constants.
package obd_pin_pkg;
	// ============================================================
	// Single-wire transceiver mode pair
	typedef struct packed {
		logic mode1;
		logic mode0;
	} sw_mode_s;
	// Channel select pair
	typedef struct packed {
		logic sel1;
		logic sel0;
	} chan_sel_s;
	// Activity indicators, active low
	typedef struct packed {
		logic serial_rx;
		logic serial_tx;
		logic vehicle_rx;
		logic vehicle_tx;
	} activity_s;
	// Single-wire transceiver requested mode
	typedef enum logic [1:0] {
		SW_SLEEP = 2'b00,
		SW_HIGH_SPEED = 2'b01,
		SW_WAKEUP = 2'b10,
		SW_NORMAL = 2'b11
	} sw_req_e;
	// Channel choice
	typedef enum logic [1:0] {
		CH_HIGH_SPEED = 2'b00,
		CH_MEDIUM_SPEED = 2'b01,
		CH_SINGLE_WIRE = 2'b10,
		CH_RESERVED = 2'b11
	} chan_e;
	// Power state
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_LOW = 2'b01,
		PWR_WAKE_WAIT = 2'b10
	} pwr_state_e;
endpackage : obd_pin_pkg

// ---- testbench.sv ----
// Self-checking bench for the adapter pin control block.
// Assumes shortened counts; the host model drives the dual-role pin.
`timescale 1ns/10ps
module testbench;
	// ============================================================
	// Signals
	logic sys_clk_i, rst_n_i, sb_valid, ign, ign_pin, measure, baud_strap, mem_strap;
	logic mem_on, mem_off, busy, sleep_req, tool, hs_sleep, ms_sleep, key, connected;
	logic mod_sleep, pwm, bp, bm, want_attn, hs_o, ms_o, tool_o, pso, attn, lp, warm;
	logic mem_o, disc, pwr_led, mod_led, pwm_o, bp_o, bm_o;
	logic [7:0] opts;
	logic [31:0] sb_set, baud_o;
	obd_pin_pkg::sw_req_e sw_req;
	obd_pin_pkg::chan_e chan;
	obd_pin_pkg::activity_s act, act_o;
	obd_pin_pkg::sw_mode_s sw_o;
	obd_pin_pkg::chan_sel_s ch_o;
	int n_fail, checked;
	// ============================================================
	// Design and host, counts shortened so the run stays brief
	obd_adapter_pin_control #(.DEBOUNCE_CYCLES(4), .WAKE_SHORT_CYCLES(8),
		.WAKE_LONG_CYCLES(20), .DISCOVER_CYCLES(16)) dut_u (.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i), .power_control_options_i(opts), .stored_baud_valid_i(sb_valid),
		.stored_baud_setting_i(sb_set), .ignition_monitor_input_i(ign_pin),
		.measure_pin_i(measure), .baud_strap_i(baud_strap), .memory_strap_i(mem_strap),
		.memory_on_command_i(mem_on), .memory_off_command_i(mem_off), .busy_i(busy),
		.sleep_request_i(sleep_req), .sw_mode_req_i(sw_req), .chan_req_i(chan),
		.tool_load_command_i(tool), .hs_xcvr_sleep_i(hs_sleep), .ms_xcvr_sleep_i(ms_sleep),
		.key_pin_i(key), .module_connected_i(connected), .module_sleep_i(mod_sleep),
		.activity_i(act), .pwm_rx_pin_i(pwm), .bus_plus_drive_i(bp), .bus_minus_drive_i(bm),
		.single_wire_mode_o(sw_o), .channel_select_o(ch_o), .high_speed_xcvr_mode_out_o(hs_o),
		.medium_speed_xcvr_mode_out_o(ms_o), .tool_load_enable_out_o(tool_o),
		.power_switch_output_o(pso), .attention_o(attn), .low_power_o(lp),
		.warm_start_o(warm), .baud_rate_o(baud_o), .memory_enable_o(mem_o),
		.discoverable_o(disc), .power_indicator_o(pwr_led), .module_indicator_o(mod_led),
		.activity_indicator_o(act_o), .pwm_rx_active_o(pwm_o), .bus_plus_tx_o(bp_o),
		.bus_minus_tx_o(bm_o));
	host_model host_u (.sys_clk_i(sys_clk_i), .want_attn_i(want_attn),
		.busy_mode_i(~opts[7]), .busy_pin_i(pso), .ign_level_i(ign), .pin_o(ign_pin));
	// ============================================================
	// Clock and helpers
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Pass edges, then step past them so outputs are settled
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : cyc
	// Bounded wait on one flag: 0 low power, 1 warm start, 2 attention, 3 discoverable
	task automatic wait_on(input int sel, input logic exp, input int n);
		logic v;
		v = ~exp;
		for (int k = 0; k < n && v !== exp; k++) begin
			cyc(1);
			case (sel)
				0: v = lp;
				1: v = warm;
				2: v = attn;
				default: v = disc;
			endcase
		end
		chk(v, exp);
	endtask : wait_on
	// Reset with chosen strap levels, held three cycles
	task automatic do_reset(input logic bs, input logic ms);
		@(posedge sys_clk_i);
		baud_strap <= bs;
		mem_strap <= ms;
		rst_n_i <= 1'b0;
		cyc(2);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		cyc(6);
	endtask : do_reset
	// One-cycle memory command pulse
	task automatic mem_cmd(input logic on);
		@(posedge sys_clk_i);
		mem_on <= on;
		mem_off <= ~on;
		@(posedge sys_clk_i);
		mem_on <= 1'b0;
		mem_off <= 1'b0;
		cyc(2);
	endtask : mem_cmd
	task automatic final_report;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		#60000;
		n_fail++;
		final_report();
	end
	// ============================================================
	// Tests
	initial begin
		{rst_n_i, sb_valid, measure, mem_on, mem_off, busy, sleep_req, tool} = '0;
		{hs_sleep, ms_sleep, connected, mod_sleep, pwm, bp, bm, want_attn} = '0;
		{ign, key, baud_strap, mem_strap} = 4'hF;
		opts = 8'h80;
		sb_set = 32'h0003D090;
		sw_req = obd_pin_pkg::SW_SLEEP;
		chan = obd_pin_pkg::CH_HIGH_SPEED;
		act = obd_pin_pkg::activity_s'(4'h0);
		cyc(2);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		cyc(6);
		chk(baud_o, 32'h0001C200);
		chk(mem_o, 1'b1);
		chk(pso, 1'b0);
		mem_cmd(1'b0);
		chk(mem_o, 1'b0);
		mem_cmd(1'b1);
		chk(mem_o, 1'b1);
		do_reset(1'b0, 1'b0);
		chk(baud_o, 32'h00002580);
		chk(mem_o, 1'b0);
		sb_valid <= 1'b1;
		do_reset(1'b1, 1'b1);
		chk(baud_o, sb_set);
		// Every code of the mode and channel pins, both levels of the module and activity indicator pins
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk_i);
			sw_req <= obd_pin_pkg::sw_req_e'(i[1:0]);
			chan <= obd_pin_pkg::chan_e'(i[1:0]);
			{tool, hs_sleep, pwm, bp} <= {4{i[0]}};
			{ms_sleep, mod_sleep, bm} <= {3{i[1]}};
			act <= obd_pin_pkg::activity_s'(4'h1 << i);
			cyc(2);
			chk(sw_o, i[1:0]);
			chk(ch_o, i[1:0]);
			chk({tool_o, hs_o, bp_o}, {3{i[0]}});
			chk({ms_o, mod_led, bm_o}, {3{i[1]}});
			chk(pwm_o, !i[0]);
			chk(act_o, {28'h0000000, ~(4'h1 << i)});
		end
		// Busy role with attention held by the host until idle
		@(posedge sys_clk_i);
		opts <= 8'h00;
		busy <= 1'b1;
		want_attn <= 1'b1;
		@(posedge sys_clk_i);
		want_attn <= 1'b0;
		cyc(1);
		chk(pso, 1'b1);
		wait_on(2, 1'b1, 6);
		cyc(4);
		chk(attn, 1'b1);
		@(posedge sys_clk_i);
		busy <= 1'b0;
		cyc(2);
		chk(pso, 1'b0);
		wait_on(2, 1'b0, 8);
		// Default options still give attention, never sleep
		@(posedge sys_clk_i);
		opts <= 8'h80;
		want_attn <= 1'b1;
		wait_on(2, 1'b1, 6);
		chk(lp, 1'b0);
		want_attn <= 1'b0;
		wait_on(2, 1'b0, 8);
		// Power output rest level, core sleep, measurement wake
		@(posedge sys_clk_i);
		opts <= 8'hC0;
		sleep_req <= 1'b1;
		@(posedge sys_clk_i);
		sleep_req <= 1'b0;
		wait_on(0, 1'b1, 6);
		cyc(2);
		chk({pso, pwr_led}, 2'b00);
		@(posedge sys_clk_i);
		measure <= 1'b1;
		wait_on(0, 1'b0, 8);
		cyc(2);
		chk({pso, pwr_led}, 2'b11);
		// Ignition: a short glitch is ignored, a long low sleeps
		@(posedge sys_clk_i);
		opts <= 8'h84;
		ign <= 1'b0;
		@(posedge sys_clk_i);
		@(posedge sys_clk_i);
		ign <= 1'b1;
		cyc(12);
		chk(lp, 1'b0);
		@(posedge sys_clk_i);
		ign <= 1'b0;
		cyc(4);
		chk(lp, 1'b0);
		wait_on(0, 1'b1, 10);
		@(posedge sys_clk_i);
		ign <= 1'b1;
		cyc(6);
		chk(lp, 1'b1);
		wait_on(1, 1'b1, 12);
		cyc(2);
		chk(lp, 1'b0);
		// Long wake delay selected
		@(posedge sys_clk_i);
		opts <= 8'h86;
		ign <= 1'b0;
		wait_on(0, 1'b1, 14);
		@(posedge sys_clk_i);
		ign <= 1'b1;
		cyc(18);
		chk(lp, 1'b1);
		wait_on(1, 1'b1, 12);
		// Key press while unconnected, then while connected
		@(posedge sys_clk_i);
		key <= 1'b0;
		wait_on(3, 1'b1, 6);
		cyc(10);
		chk(disc, 1'b1);
		wait_on(3, 1'b0, 14);
		@(posedge sys_clk_i);
		key <= 1'b1;
		connected <= 1'b1;
		@(posedge sys_clk_i);
		key <= 1'b0;
		cyc(10);
		chk(disc, 1'b0);
		final_report();
	end
endmodule : testbench
